// >>> src/sgf_framer.sv
// sgf_framer: apb-controlled serial sub-network framer with i/o images
// assumes inputs synchronous to clk_i; rs485 direction follows txen_o
//
// What this block does
// - image splits into 16-bit bit blocks, word part directly after
// - bit part is size up to 2, then 2 bytes per 10-byte step
// - image is addressed per byte only, no bit addressing
// - locked start waits for host go flag before sub-network traffic
// - no-lock variant keeps control/status but starts without go flag
// - control/status disabled removes control and status registers
// - fatal error with auto restart restarts silently
// - fatal error without auto restart halts and raises error
// - master mode sends queries and collects slave responses
// - generic mode produces and consumes messages freely
// - df1 mode is master only, half-duplex
// - receive and transmit counters count successful transactions
// - counters sit at configurable in-image locations
// - one option enables both counters
// - eight selectable bit rates from 1200 to 57600
// - 7 or 8 data bits
// - parity none, odd or even, generated and checked
// - one or two stop bits
// - start/end characters only in generic mode
// - start and end bytes configurable and separately enabled
// - master gap in 10 ms steps, zero means 3.5 characters
// - generic gap in 10 us steps
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ns
module sgf_framer #(
	parameter int unsigned CLK_HZ = sgf_pkg::CLK_HZ
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// serial line
	input  wire logic        rxd_i,
	output logic             txd_o,
	output logic             txen_o,
	// status
	output logic             err_o,
	output logic             run_o
);
	import sgf_pkg::*;

	localparam int unsigned CYC_MS = CLK_HZ / 1000 * MS_UNIT;
	localparam int unsigned CYC_US = CLK_HZ / 1_000_000 * US_UNIT;

	sgf_state_s s_q, s_d;
	logic [7:0]  in_mem [512];
	logic [7:0]  out_mem [512];
	logic        mem_we;
	logic [8:0]  mem_wa;
	logic [7:0]  mem_wd;
	logic        out_we;
	logic [17:0] div;
	logic [1:0]  mode, cs, par;
	logic        db8, gen, run, gap_done, acc, valid, fatal, rx_ok, ld;
	logic [7:0]  rx_b, ld_b;
	logic [11:0] frm;
	logic [39:0] need;
	logic [3:0]  nb;
	logic [31:0] rd;
	logic [2:0]  win;

	function automatic logic [17:0] bdiv(input logic [2:0] i);
		return 18'(CLK_HZ / baud_of(i));
	endfunction : bdiv

	function automatic logic par_of(input logic [7:0] d, input logic b8, input logic [1:0] p);
		return (^{b8 & d[7], d[6:0]}) ^ (p == PAR_ODD);
	endfunction : par_of

	function automatic logic [7:0] split(input logic [9:0] sz);
		if (sz <= BIT_ONLY)
			return sz[7:0];
		return 8'((sz + 10'(BIT_STEP - 1)) / 10'(BIT_STEP) * 10'(BIT_BLK));
	endfunction : split

	// counters overlaid on the in image
	function automatic logic [7:0] ib(input logic [8:0] a);
		logic [7:0] b;
		b = in_mem[a];
		if (s_q.cfg[F_STATS]) begin
			if (a == s_q.rcnt_loc)
				b = s_q.cnt_rx[7:0];
			if (a == 9'(s_q.rcnt_loc + 9'd1))
				b = s_q.cnt_rx[15:8];
			if (a == s_q.tcnt_loc)
				b = s_q.cnt_tx[7:0];
			if (a == 9'(s_q.tcnt_loc + 9'd1))
				b = s_q.cnt_tx[15:8];
		end
		return b;
	endfunction : ib

	always_comb begin
		s_d    = s_q;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		rx_ok  = 1'b0;
		rx_b   = 8'h00;
		fatal  = 1'b0;
		ld     = 1'b0;
		ld_b   = 8'h00;
		frm    = 12'hfff;
		rd     = '0;
		mode   = s_q.cfg[F_MODE +: 2];
		cs     = s_q.cfg[F_CS +: 2];
		par    = s_q.cfg[F_PAR +: 2];
		db8    = s_q.cfg[F_DB8];
		gen    = (mode == MODE_GEN);
		div    = bdiv(s_q.cfg[F_BAUD +: 3]);
		nb     = 4'd9 + {3'd0, db8} + {3'd0, par != PAR_NONE} + {3'd0, s_q.cfg[F_STOP2]};
		run    = !s_q.halt && (cs != CS_LOCK || s_q.go);
		// generic gap in 10 us steps
		if (gen)
			need = 40'(s_q.delim) * 40'(CYC_US);
		// master gap, zero gives 3.5 chars
		else if (s_q.delim != 16'h0000)
			need = 40'(s_q.delim) * 40'(CYC_MS);
		else
			need = (40'(nb) * 40'(div) * 40'd7 + 40'd1) >> 1;

		// line silence timer, saturating
		if (s_q.rx_on || s_q.tx_busy || !rxd_i)
			s_d.gap = '0;
		else if (!(&s_q.gap))
			s_d.gap = s_q.gap + 40'd1;
		gap_done = (s_q.gap >= need);

		// receiver; master modes rx only after the query, generic rx in any state but halt
		if (!s_q.rx_on) begin
			if (!rxd_i && run && (gen ? s_q.st != ST_HALT : s_q.st == ST_RXW)) begin
				s_d.rx_on  = 1'b1;
				s_d.rx_cnt = div >> 1;
				s_d.rx_idx = 4'd0;
			end
		end else if (s_q.rx_cnt != 18'd0) begin
			s_d.rx_cnt = s_q.rx_cnt - 18'd1;
		end else begin
			s_d.rx_cnt = div - 18'd1;
			s_d.rx_idx = s_q.rx_idx + 4'd1;
			if (s_q.rx_idx == 4'd0) begin
				if (rxd_i)
					s_d.rx_on = 1'b0;
			end else if (s_q.rx_idx < nb - {3'd0, s_q.cfg[F_STOP2]} - 4'd1) begin
				s_d.rx_sh[s_q.rx_idx - 4'd1] = rxd_i;
			end else begin
				s_d.rx_on = 1'b0;
				rx_b = {db8 & s_q.rx_sh[7], s_q.rx_sh[6:0]};
				if (!rxd_i)
					fatal = 1'b1;
				else if (par != PAR_NONE && s_q.rx_sh[db8 ? 8 : 7] != par_of(rx_b, db8, par))
					fatal = 1'b1;
				else
					rx_ok = 1'b1;
			end
		end

		if (s_q.tx_busy) begin
			if (s_q.tx_cnt != 18'd0) begin
				s_d.tx_cnt = s_q.tx_cnt - 18'd1;
			end else if (s_q.tx_n == 4'd1) begin
				s_d.tx_busy = 1'b0;
				s_d.txd     = 1'b1;
			end else begin
				s_d.tx_sh  = s_q.tx_sh >> 1;
				s_d.txd    = s_q.tx_sh[1];
				s_d.tx_n   = s_q.tx_n - 4'd1;
				s_d.tx_cnt = div - 18'd1;
			end
		end

		if (rx_ok && gen) begin
			if (s_q.cfg[F_USE_S] && !s_q.rx_msg) begin
				if (rx_b == s_q.chars[7:0]) begin
					s_d.rx_msg = 1'b1;
					s_d.rx_pos = '0;
				end
			end else if (s_q.cfg[F_USE_E] && rx_b == s_q.chars[15:8]) begin
				s_d.rx_msg = 1'b0;
				s_d.rx_pos = '0;
				if (s_q.cfg[F_STATS])
					s_d.cnt_rx = s_q.cnt_rx + 16'd1;
			end else begin
				mem_we     = 1'b1;
				s_d.rx_msg = 1'b1;
				s_d.rx_pos = s_q.rx_pos + 9'd1;
			end
		end else if (rx_ok) begin
			mem_we     = 1'b1;
			s_d.rx_got = 1'b1;
			s_d.rx_pos = s_q.rx_pos + 9'd1;
		end
		mem_wa = 9'(s_q.rx_off + s_q.rx_pos);
		mem_wd = rx_b;
		if (gen && s_q.rx_msg && gap_done) begin
			s_d.rx_msg = 1'b0;
			s_d.rx_pos = '0;
			if (s_q.cfg[F_STATS])
				s_d.cnt_rx = s_q.cnt_rx + 16'd1;
		end

		// message engine
		case (s_q.st)
			ST_IDLE: begin
				if (run && s_q.kick && gap_done && !s_q.rx_on) begin
					s_d.kick = 1'b0;
					s_d.st   = ST_TX;
					s_d.pos  = '0;
					s_d.ph   = (gen && s_q.cfg[F_USE_S]) ? 2'd0 : 2'd1;
				end
			end
			ST_TX: begin
				if (!s_q.tx_busy) begin
					case (s_q.ph)
						2'd0: begin
							ld       = 1'b1;
							ld_b     = s_q.chars[7:0];
							s_d.ph   = 2'd1;
						end
						2'd1: begin
							if (s_q.pos < s_q.tx_len) begin
								ld      = 1'b1;
								ld_b    = out_mem[9'(s_q.tx_off + s_q.pos[8:0])];
								s_d.pos = s_q.pos + 10'd1;
							end else begin
								s_d.ph  = 2'd2;
							end
						end
						2'd2: begin
							// end byte appended in generic only
							ld     = gen && s_q.cfg[F_USE_E];
							ld_b   = s_q.chars[15:8];
							s_d.ph = 2'd3;
						end
						default: begin
							if (s_q.cfg[F_STATS])
								s_d.cnt_tx = s_q.cnt_tx + 16'd1;
							s_d.st     = gen ? ST_IDLE : ST_RXW;
							s_d.rx_pos = '0;
							s_d.rx_got = 1'b0;
						end
					endcase
				end
			end
			ST_RXW: begin
				if (gap_done && !s_q.rx_on) begin
					s_d.st = ST_IDLE;
					if (s_q.rx_got && s_q.cfg[F_STATS])
						s_d.cnt_rx = s_q.cnt_rx + 16'd1;
				end
			end
			ST_HALT: begin
			end
			default: s_d.st = ST_IDLE;
		endcase

		if (ld) begin
			frm = {3'b111, ld_b, 1'b0};
			if (!db8)
				frm[8] = 1'b1;
			if (par != PAR_NONE)
				frm[db8 ? 9 : 8] = par_of(ld_b, db8, par);
			s_d.tx_busy = 1'b1;
			s_d.tx_sh   = frm;
			s_d.txd     = 1'b0;
			s_d.tx_n    = nb;
			s_d.tx_cnt  = div - 18'd1;
		end

		if (fatal) begin
			s_d.st      = s_q.cfg[F_AUTO] ? ST_IDLE : ST_HALT;
			s_d.halt    = !s_q.cfg[F_AUTO];
			s_d.rx_on   = 1'b0;
			s_d.rx_msg  = 1'b0;
			s_d.rx_pos  = '0;
			s_d.tx_busy = 1'b0;
			s_d.txd     = 1'b1;
			s_d.kick    = 1'b0;
		end

		// apb: access takes two cycles, data settled in the first
		acc   = psel_i && penable_i;
		win   = paddr_i[11:9];
		valid = (win == WIN_REG && paddr_i <= A_KICK) || (win == WIN_IN && !pwrite_i) ||
			win == WIN_OUT;
		case (paddr_i)
			// control and status read zero when disabled
			A_CTRL:   rd = {31'd0, cs != CS_OFF && s_q.go};
			A_CFG:    rd = {17'd0, s_q.cfg};
			A_CHARS:  rd = {16'd0, s_q.chars};
			A_DELIM:  rd = {16'd0, s_q.delim};
			A_XFER:   rd = {7'd0, s_q.tx_off, 6'd0, s_q.tx_len};
			A_RXOFF:  rd = {23'd0, s_q.rx_off};
			A_CNTLOC: rd = {7'd0, s_q.tcnt_loc, 7'd0, s_q.rcnt_loc};
			A_IOSIZE: rd = {6'd0, s_q.out_size, 6'd0, s_q.in_size};
			A_STATUS: rd = (cs == CS_OFF) ? 32'h0 : {27'd0, s_q.kick, s_q.rx_msg,
				s_q.st != ST_IDLE, s_q.halt, run};
			A_COUNT:  rd = {s_q.cnt_tx, s_q.cnt_rx};
			// word part starts at the bit part size
			A_SPLIT:  rd = {8'd0, split(s_q.out_size), 8'd0, split(s_q.in_size)};
			default: begin
				if (win == WIN_IN)
					rd = {ib({paddr_i[8:2], 2'd3}), ib({paddr_i[8:2], 2'd2}),
						ib({paddr_i[8:2], 2'd1}), ib({paddr_i[8:2], 2'd0})};
				else if (win == WIN_OUT)
					rd = {out_mem[{paddr_i[8:2], 2'd3}], out_mem[{paddr_i[8:2], 2'd2}],
						out_mem[{paddr_i[8:2], 2'd1}], out_mem[{paddr_i[8:2], 2'd0}]};
				else
					rd = 32'h0;
			end
		endcase
		out_we = acc && s_q.ack && pwrite_i && win == WIN_OUT;
		if (acc && !s_q.ack) begin
			s_d.ack    = 1'b1;
			s_d.slverr = !valid;
			s_d.prdata = valid ? rd : 32'h0;
		end else if (acc && s_q.ack) begin
			s_d.ack = 1'b0;
			if (pwrite_i && valid) begin
				case (paddr_i)
					A_CTRL: begin
						if (cs != CS_OFF) begin
							s_d.go = pwdata_i[0];
							if (pwdata_i[1] && s_q.halt && !fatal) begin
								s_d.halt = 1'b0;
								s_d.st   = ST_IDLE;
							end
						end
					end
					A_CFG:    s_d.cfg      = pwdata_i[14:0];
					A_CHARS:  s_d.chars    = pwdata_i[15:0];
					A_DELIM:  s_d.delim    = pwdata_i[15:0];
					A_XFER: begin
						s_d.tx_len = pwdata_i[9:0];
						s_d.tx_off = pwdata_i[24:16];
					end
					A_RXOFF:  s_d.rx_off   = pwdata_i[8:0];
					A_CNTLOC: begin
						s_d.rcnt_loc = pwdata_i[8:0];
						s_d.tcnt_loc = pwdata_i[24:16];
					end
					A_IOSIZE: begin
						s_d.in_size  = pwdata_i[9:0];
						s_d.out_size = pwdata_i[25:16];
					end
					// request set wins over the engine taking it
					A_KICK: begin
						if (pwdata_i[0])
							s_d.kick = 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			s_q <= S_RST;
		else
			s_q <= s_d;
	end

	// image storage has no reset; contents undefined until written
	always_ff @(posedge clk_i) begin
		if (mem_we)
			in_mem[mem_wa] <= mem_wd;
		for (int k = 0; k < 4; k++) begin
			if (out_we && pstrb_i[k])
				out_mem[{paddr_i[8:2], 2'(k)}] <= pwdata_i[8*k +: 8];
		end
	end

	assign prdata_o  = s_q.prdata;
	assign pready_o  = penable_i && s_q.ack;
	assign pslverr_o = penable_i && s_q.ack && s_q.slverr;
	assign txd_o     = s_q.txd;
	assign txen_o    = s_q.tx_busy;
	assign err_o     = s_q.halt;
	assign run_o     = run;
endmodule : sgf_framer

// >>> src/sgf_pkg.sv
// sgf_pkg: constants, register map and state types of the serial framer
// assumes a single 250 MHz clock and a 12-bit apb byte address
package sgf_pkg;
	localparam int unsigned CLK_HZ    = 250_000_000;
	localparam int unsigned MS_UNIT   = 10;
	localparam int unsigned US_UNIT   = 10;
	localparam int unsigned BIT_BLK   = 2;
	localparam int unsigned BIT_STEP  = 10;
	localparam logic [9:0]  BIT_ONLY  = 10'h002;

	// register byte addresses
	localparam logic [11:0] A_CTRL    = 12'h000;
	localparam logic [11:0] A_CFG     = 12'h004;
	localparam logic [11:0] A_CHARS   = 12'h008;
	localparam logic [11:0] A_DELIM   = 12'h00c;
	localparam logic [11:0] A_XFER    = 12'h010;
	localparam logic [11:0] A_RXOFF   = 12'h014;
	localparam logic [11:0] A_CNTLOC  = 12'h018;
	localparam logic [11:0] A_IOSIZE  = 12'h01c;
	localparam logic [11:0] A_STATUS  = 12'h020;
	localparam logic [11:0] A_COUNT   = 12'h024;
	localparam logic [11:0] A_SPLIT   = 12'h028;
	localparam logic [11:0] A_KICK    = 12'h02c;
	localparam logic [2:0]  WIN_REG   = 3'h0;
	localparam logic [2:0]  WIN_IN    = 3'h1;
	localparam logic [2:0]  WIN_OUT   = 3'h2;

	// cfg field positions
	localparam int unsigned F_BAUD    = 0;
	localparam int unsigned F_DB8     = 3;
	localparam int unsigned F_PAR     = 4;
	localparam int unsigned F_STOP2   = 6;
	localparam int unsigned F_MODE    = 7;
	localparam int unsigned F_CS      = 9;
	localparam int unsigned F_AUTO    = 11;
	localparam int unsigned F_STATS   = 12;
	localparam int unsigned F_USE_S   = 13;
	localparam int unsigned F_USE_E   = 14;

	// reset values: 9600 bit/s, 8N1, master mode, locked start, stats on
	localparam logic [14:0] CFG_RST   = 15'h108b;
	localparam logic [15:0] CHARS_RST = 16'h0000;
	localparam logic [15:0] DELIM_RST = 16'h0000;

	localparam logic [1:0]  MODE_GEN  = 2'h0;
	localparam logic [1:0]  MODE_MST  = 2'h1;
	localparam logic [1:0]  MODE_DF1  = 2'h2;
	localparam logic [1:0]  CS_LOCK   = 2'h0;
	localparam logic [1:0]  CS_NOLOCK = 2'h1;
	localparam logic [1:0]  CS_OFF    = 2'h2;
	localparam logic [1:0]  PAR_NONE  = 2'h0;
	localparam logic [1:0]  PAR_ODD   = 2'h1;
	localparam logic [1:0]  PAR_EVEN  = 2'h2;

	function automatic int unsigned baud_of(input logic [2:0] i);
		case (i)
			3'h0:    return 1200;
			3'h1:    return 2400;
			3'h2:    return 4800;
			3'h3:    return 9600;
			3'h4:    return 19200;
			3'h5:    return 35700;
			3'h6:    return 38400;
			default: return 57600;
		endcase
	endfunction : baud_of

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_TX   = 4'b0010,
		ST_RXW  = 4'b0100,
		ST_HALT = 4'b1000
	} sgf_st_e;

	typedef struct packed {
		logic [31:0] prdata;
		logic        ack;
		logic        slverr;
		logic        go;
		logic [14:0] cfg;
		logic [15:0] chars;
		logic [15:0] delim;
		logic [8:0]  tx_off;
		logic [9:0]  tx_len;
		logic [8:0]  rx_off;
		logic [8:0]  rcnt_loc;
		logic [8:0]  tcnt_loc;
		logic [9:0]  in_size;
		logic [9:0]  out_size;
		logic        kick;
		logic        halt;
		sgf_st_e     st;
		logic [1:0]  ph;
		logic [9:0]  pos;
		logic        tx_busy;
		logic [11:0] tx_sh;
		logic [3:0]  tx_n;
		logic [17:0] tx_cnt;
		logic        txd;
		logic        rx_on;
		logic [17:0] rx_cnt;
		logic [3:0]  rx_idx;
		logic [9:0]  rx_sh;
		logic        rx_msg;
		logic        rx_got;
		logic [8:0]  rx_pos;
		logic [39:0] gap;
		logic [15:0] cnt_rx;
		logic [15:0] cnt_tx;
	} sgf_state_s;

	localparam sgf_state_s S_RST = '{cfg: CFG_RST, chars: CHARS_RST, delim: DELIM_RST,
		st: ST_IDLE, txd: 1'b1, default: '0};
endpackage : sgf_pkg

// >>> sim/sgf_framer_properties.sv
// sgf_checker: port-level timing checks of the serial framer
// assumes bound to sgf_framer with a scaled-down clock rate
`timescale 1ns/1ns
module sgf_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// serial and status
	input wire logic txd_o,
	input wire logic txen_o,
	input wire logic err_o,
	input wire logic run_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	apb_one_wait_a: assert property (psel_i && !penable_i ##1 psel_i && penable_i
		|-> !pready_o ##1 pready_o) else $error("apb answer not after one wait state");
	err_with_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error answer without ready");
	halt_quiet_a: assert property (err_o |-> !run_o && !txen_o)
		else $error("halted engine still runs");
	idle_mark_a: assert property (!txen_o |-> txd_o)
		else $error("line not idle high outside a character");
	start_space_a: assert property ($rose(txen_o) |-> !txd_o)
		else $error("character does not open with a low start bit");
	stop_mark_a: assert property ($fell(txen_o) |-> $past(txd_o))
		else $error("character does not end on a high stop bit");
	bit_hold_a: assert property ($changed(txd_o) |=> $stable(txd_o)[*8])
		else $error("serial bit shorter than the bit period");
	lock_quiet_a: assert property (!run_o && !txen_o |=> !txen_o)
		else $error("transmission started while not running");
endmodule : sgf_checker

bind sgf_framer sgf_checker u_chk (
	.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .txd_o(txd_o), .txen_o(txen_o),
	.err_o(err_o), .run_o(run_o));

// >>> sim/sgf_node.sv
// sgf_node: behavioural sub-network node, 8 data bits, no parity, 1 stop
// assumes DIV clock cycles per bit; line idles high like a pulled-up pair
`timescale 1ns/1ns
module sgf_node #(
	parameter int DIV = 34
) (
	input  wire logic clk_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	logic [7:0] got[$];
	logic       tail[$];
	logic [7:0] sh;
	int         i;

	initial rxd_o = 1'b1;

	always begin
		@(negedge txd_i);
		repeat (DIV / 2) @(posedge clk_i);
		for (i = 0; i < 8; i++) begin
			repeat (DIV) @(posedge clk_i);
			sh[i] = txd_i;
		end
		repeat (DIV) @(posedge clk_i);
		// bit after the data: parity or stop
		tail.push_back(txd_i);
		got.push_back(sh);
	end

	// send one frame; bad clears the stop bit
	task automatic send(input logic [7:0] b, input logic bad);
		int k;
		@(posedge clk_i);
		rxd_o <= 1'b0;
		repeat (DIV) @(posedge clk_i);
		for (k = 0; k < 8; k++) begin
			rxd_o <= b[k];
			repeat (DIV) @(posedge clk_i);
		end
		rxd_o <= !bad;
		repeat (DIV) @(posedge clk_i);
		rxd_o <= 1'b1;
	endtask : send
endmodule : sgf_node

// >>> sim/sgf_framer_tb_top.sv
// sgf_framer_tb_top: self-checking bench of the serial framer
// assumes a scaled clock rate so that 57600 bit/s is 34 cycles a bit
`timescale 1ns/1ns
module sgf_framer_tb_top;
	import sgf_pkg::*;
	localparam int unsigned HZ  = 2_000_000;
	localparam int          DIV = HZ / 57600;
	logic        clk_i    = 1'b0;
	logic        resetn_i = 1'b0;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [11:0] paddr    = 12'h000;
	logic [31:0] pwdata   = 32'h0;
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, rerr, rxd, txd, txen, err, run;
	int          failures, cmp_count, cyc;

	always #2 clk_i = ~clk_i;

	sgf_framer #(.CLK_HZ(HZ)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.rxd_i(rxd), .txd_o(txd), .txen_o(txen), .err_o(err), .run_o(run));
	sgf_node #(.DIV(DIV)) node (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));

	task automatic tally_and_finish;
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// hang guard, well above the ~15k cycles the run needs
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			tally_and_finish;
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		// answer time is the slave's; only the hang guard ends this wait
		do
			@(posedge clk_i);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd

	// bytes seen by the node, byte k in e[8k+7:8k]
	task automatic chk_seq(input int n, input logic [39:0] e);
		int k;
		k = 0;
		while (node.got.size() < n && k < 8000) begin
			@(posedge clk_i);
			k++;
		end
		while (txen === 1'b1) @(posedge clk_i);
		repeat (4) @(posedge clk_i);
		chk(32'(node.got.size()), 32'(n));
		for (k = 0; k < n; k++) chk({24'h0, node.got[k]}, {24'h0, e[8*k +: 8]});
		node.got.delete();
	endtask : chk_seq

	task automatic t_reset;
		chk({28'h0, txen, run, txd, err}, 32'h2);
		rd(A_CFG, 32'(CFG_RST));
	endtask : t_reset

	task automatic t_split;
		int sz[10] = '{1, 2, 10, 11, 12, 20, 21, 505, 511, 512};
		int bp[10] = '{1, 2, 2, 4, 4, 4, 6, 102, 104, 104};
		for (int i = 0; i < 10; i++) begin
			wr(A_IOSIZE, {6'h0, 10'd512, 6'h0, 10'(sz[i])});
			rd(A_SPLIT, {8'h0, 8'd104, 8'h0, 8'(bp[i])});
		end
	endtask : t_split

	task automatic t_lock;
		wr(A_CFG, 32'h700f);
		wr(A_CHARS, 32'h0a1b);
		wr(A_DELIM, 32'h2);
		wr(A_CNTLOC, 32'h0012_0010);
		wr(A_RXOFF, 32'h4);
		wr(12'h400, 32'h4433_2211);
		wr(A_XFER, 32'h3);
		wr(A_KICK, 32'h1);
		repeat (1500) @(posedge clk_i);
		chk(32'(node.got.size()), 32'h0);
		wr(A_CTRL, 32'h1);
		chk_seq(5, 40'h0a_3322_111b);
		rd(A_COUNT, 32'h0001_0000);
	endtask : t_lock

	task automatic t_master;
		logic [1:0] md[2] = '{MODE_MST, MODE_DF1};
		wr(A_DELIM, 32'h0);
		for (int i = 0; i < 2; i++) begin
			wr(A_CFG, 32'h700f | (32'(md[i]) << F_MODE));
			wr(A_KICK, 32'h1);
			chk_seq(3, 40'h33_2211);
			node.send(8'h77 + 8'(i), 1'b0);
			repeat (1400) @(posedge clk_i);
			apb(1'b0, 12'h204, 32'h0);
			chk({24'h0, rdat[7:0]}, 32'h77 + 32'(i));
		end
	endtask : t_master

	task automatic t_rx;
		logic [7:0] m[4] = '{8'h1b, 8'h55, 8'h66, 8'h0a};
		wr(A_CFG, 32'h700f);
		wr(A_DELIM, 32'h2);
		for (int i = 0; i < 4; i++) node.send(m[i], 1'b0);
		repeat (100) @(posedge clk_i);
		apb(1'b0, 12'h204, 32'h0);
		chk({16'h0, rdat[15:0]}, 32'h6655);
		rd(12'h210, 32'h0003_0003);
		rd(A_COUNT, 32'h0003_0003);
		wr(A_CFG, 32'h600f);
		for (int i = 0; i < 4; i++) node.send(m[i], 1'b0);
		repeat (100) @(posedge clk_i);
		rd(A_COUNT, 32'h0003_0003);
	endtask : t_rx

	task automatic t_err;
		node.send(8'h00, 1'b1);
		repeat (40) @(posedge clk_i);
		chk({30'h0, err, run}, 32'h2);
		wr(A_CTRL, 32'h3);
		repeat (4) @(posedge clk_i);
		chk({30'h0, err, run}, 32'h1);
		wr(A_CFG, 32'h680f);
		node.send(8'h00, 1'b1);
		repeat (40) @(posedge clk_i);
		chk({30'h0, err, run}, 32'h1);
	endtask : t_err

	// 8 data bits, even parity, two stop bits, no start/end characters
	task automatic t_frame;
		wr(A_CFG, 32'h086f);
		wr(12'h400, 32'h0000_3107);
		node.tail.delete();
		wr(A_KICK, 32'h1);
		chk_seq(3, 40'h00_3107);
		for (int k = 0; k < 3; k++) begin
			chk(32'(node.tail[k]), 32'(k < 2));
		end
	endtask : t_frame

	task automatic t_bus;
		apb(1'b0, 12'h030, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, 12'h200, 32'h1);
		chk({31'h0, rerr}, 32'h1);
		wr(A_CTRL, 32'h0);
		wr(A_CFG, 32'h620f);
		@(posedge clk_i);
		chk({31'h0, run}, 32'h1);
		rd(A_CTRL, 32'h0);
		wr(A_CTRL, 32'h1);
		rd(A_CTRL, 32'h1);
		rd(A_STATUS, 32'h1);
		wr(A_CFG, 32'h640f);
		wr(A_CTRL, 32'h1);
		rd(A_CTRL, 32'h0);
		rd(A_STATUS, 32'h0);
	endtask : t_bus

	initial begin
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		t_reset;
		t_split;
		t_lock;
		t_master;
		t_rx;
		t_err;
		t_frame;
		t_bus;
		tally_and_finish;
	end
endmodule : sgf_framer_tb_top
